/* logic/buffer_channel_word_update.sv */
// Purpose: Buffer channel control tail: address advance, data move, termination.
// Assumes: Core storage answers on the clk_sys domain with core_done.
// Notes:   One time slot per clock; the slot counter stalls at resume points.
`timescale 1ns/1ps

// Notes on behaviour
// - Slot 06: current address plus one formed
// - Capture address bits for selector upper bits
// - Slot 08: updated address written back upper
// - Area reference: selector reloaded from captures
// - Input: word stored slot 13, area preset
// - Slot 16: selector reloaded from scanner
// - Output gate on slot 18, off 20
// - Slot 21: output ready or input resume
// - Slot 22: channel request flag dropped
// - Slots 25/26: compare word cleared, loaded
// - Slot 32: aux, wait, read flags cleared
// - Halves differ sets active, equal clears
// - Six active flags, selector picks one
// - Area reference sets storage enable flag
// - Upper or lower half written separately
// - Activate sets both storage busy flags
// - Area read gates designated control word
// - Pending code to selector after wait
// - Preset half to ones, then zeros transfer
// - Area reference end clears busy flags
// - Address bits to words, whole word to core
// - Compare word: current upper, terminal lower
module buffer_channel_word_update #(
  parameter int ADDR_W = buf_chan_pkg::ADDR_W,
  parameter int WORD_W = buf_chan_pkg::WORD_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Core storage
  output logic                   core_start,
  output logic                   core_write,
  output logic      [ADDR_W-1:0] core_addr,
  output logic      [WORD_W-1:0] core_wdata,
  input  wire logic [WORD_W-1:0] core_rdata,
  input  wire logic              core_done,
  // Equipment adaptors
  input  wire logic [5:0]        chan_req_pin,
  input  wire logic [WORD_W-1:0] in_word_pin,
  output logic      [WORD_W-1:0] out_word,
  output logic      [5:0]        out_load,
  output logic      [5:0]        out_ready,
  output logic      [5:0]        in_resume_b,
  output logic      [5:0]        buffer_active
);

  localparam int UL = buf_chan_pkg::UADDR_LSB;
  localparam int LL = buf_chan_pkg::LADDR_LSB;

  // Field positions must fit the word
  if (ADDR_W != buf_chan_pkg::ADDR_W || WORD_W < UL + ADDR_W) begin : g_chk
    $error("buffer_channel_word_update: unsupported widths");
  end

  // Address field mask of a storage word
  localparam logic [WORD_W-1:0] AMASK =
    ({{(WORD_W-ADDR_W){1'b0}}, {ADDR_W{1'b1}}} << UL) |
    ({{(WORD_W-ADDR_W){1'b0}}, {ADDR_W{1'b1}}} << LL);

  // Address in the control word area
  function automatic logic in_area(input logic [ADDR_W-1:0] a);
    in_area = (a >= buf_chan_pkg::AREA_LO) && (a <= buf_chan_pkg::AREA_HI);
  endfunction

  // Valid channel code
  function automatic logic code_ok(input logic [2:0] c);
    code_ok = (c >= buf_chan_pkg::CODE_LO) && (c <= buf_chan_pkg::CODE_HI);
  endfunction

  // One-hot channel flag from a code
  function automatic logic [5:0] onehot(input logic [2:0] c);
    onehot = code_ok(c) ? 6'(6'h01 << (c - 3'h1)) : 6'h00;
  endfunction

  logic [ADDR_W-1:0] cw_u_q [1:6];     // Control words, current address
  logic [ADDR_W-1:0] cw_l_q [1:6];     // Control words, terminal address
  logic [2*ADDR_W-1:0] ccr_q;          // Common compare word
  logic [2:0]  sel_q;                  // Channel selector
  logic [2:0]  scan_q;                 // Scanner first rank
  logic [2:0]  pend_q;                 // Pending reference code
  logic [5:0]  slot_q;                 // Time slot counter
  logic        seq_q;                  // Auxiliary sequence running
  logic        aux_req_q;              // Auxiliary request flag
  logic        aux_wait_q;             // Auxiliary wait-storage flag
  logic        even_busy_q;            // Even storage busy
  logic        odd_busy_q;             // Odd storage busy
  logic        rd_lo_q;                // Lower word read enable
  logic        rd_hi_q;                // Upper word read enable
  logic        wb_en_q;                // Address writeback enable
  logic        merge_q;                // Write rank merge enable
  logic        store_en_q;             // Storage enable flag
  logic        area_q;                 // Buffer reference into area
  logic        cap_hi_q;               // Selector bit capture hi
  logic        cap_lo_q;               // Selector bit capture lo
  logic        gate_q;                 // Output gate flag
  logic        act_q;                  // Activate instruction flag
  logic        wr_u_q;                 // Program write upper pending
  logic [ADDR_W-1:0] wdat_q;           // Program write rank
  logic [5:0]  req_s1_q;               // Request synchroniser
  logic [5:0]  req_s2_q;
  logic [5:0]  req_s3_q;               // Edge history
  logic [5:0]  req_flag_q;             // Channel request flags
  logic [WORD_W-1:0] din_s1_q;         // Input word synchroniser
  logic [WORD_W-1:0] din_s2_q;
  logic [WORD_W-1:0] rank_q;           // Output read rank
  buf_chan_pkg::hss_state_e hss_q;     // Program reference state

  // Read rank view of the selected control word
  logic [2*ADDR_W-1:0] rank7;
  logic                run;
  logic                is_out;
  logic [5:0]          sel_hot;
  assign rank7   = {rd_hi_q ? cw_u_q[sel_q] : {ADDR_W{1'b0}},
                    rd_lo_q ? cw_l_q[sel_q] : {ADDR_W{1'b0}}};
  assign is_out  = ~sel_q[0];
  assign sel_hot = onehot(sel_q);
  // Slot advance stalls at the resume point
  // stall on resume
  assign run     = seq_q && !(slot_q == buf_chan_pkg::T_RESUME && !core_done);

  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      req_s1_q <= '0;
      req_s2_q <= '0;
      req_s3_q <= '0;
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      req_s1_q <= chan_req_pin;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      din_s1_q <= in_word_pin;
      din_s2_q <= din_s1_q;
    end
  end

  // Request flags: a new request wins over the drop
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      req_flag_q <= '0;
    end else begin
      req_flag_q <= (req_flag_q & ~((run && slot_q == buf_chan_pkg::T_DROP) ? sel_hot : 6'h00))
                    | (req_s2_q & ~req_s3_q);
    end
  end

  // Scanner, slot counter and sequence start
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scan_q    <= buf_chan_pkg::CODE_LO;
      slot_q    <= buf_chan_pkg::T_START;
      seq_q     <= 1'b0;
      aux_req_q <= 1'b0;
    end else if (!seq_q) begin
      if (aux_req_q && !even_busy_q && !odd_busy_q && hss_q == buf_chan_pkg::HSS_IDLE) begin
        seq_q  <= 1'b1;
        slot_q <= buf_chan_pkg::T_START;
      end else if (!aux_req_q && (req_flag_q & buffer_active & onehot(scan_q)) != 6'h00) begin
        aux_req_q <= 1'b1;
      end else if (!aux_req_q) begin
        scan_q <= (scan_q == buf_chan_pkg::CODE_HI) ? buf_chan_pkg::CODE_LO : scan_q + 3'h1;
      end
    end else if (run) begin
      slot_q <= slot_q + 6'h01;
      if (slot_q == buf_chan_pkg::T_CLRAUX && !act_q) begin
        aux_req_q <= 1'b0;
      end
      if (slot_q == buf_chan_pkg::T_TERM) begin
        seq_q <= 1'b0;
      end
    end
  end

  // Channel selector
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sel_q <= buf_chan_pkg::CODE_LO;
    end else if (run) begin
      if (slot_q == buf_chan_pkg::T_START) begin
        sel_q <= scan_q;
      end else if (slot_q == buf_chan_pkg::T_RESEL && area_q) begin
        sel_q <= {cap_hi_q, cap_lo_q, odd_busy_q};
      end else if (slot_q == buf_chan_pkg::T_OWN) begin
        sel_q <= scan_q;
      end
    end else if (hss_q == buf_chan_pkg::HSS_PRESET) begin
      sel_q <= pend_q;
    end
  end

  // Storage busy flags
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      even_busy_q <= 1'b0;
      odd_busy_q  <= 1'b0;
    end else if (run && slot_q == buf_chan_pkg::T_START) begin
      even_busy_q <= 1'b1;
      odd_busy_q  <= 1'b1;
    end else if (run && slot_q == buf_chan_pkg::T_CORE) begin
      // Keep only the unit in use
      even_busy_q <= ~ccr_q[ADDR_W];
      odd_busy_q  <= ccr_q[ADDR_W];
    end else if (reg_wr && reg_addr == buf_chan_pkg::OFS_ACT && code_ok(reg_wdata[2:0])
                 && hss_q == buf_chan_pkg::HSS_IDLE && !seq_q) begin
      even_busy_q <= 1'b1;
      odd_busy_q  <= 1'b1;
    end else if ((run && slot_q == buf_chan_pkg::T_TERM) || hss_q == buf_chan_pkg::HSS_CHECK) begin
      even_busy_q <= 1'b0;
      odd_busy_q  <= 1'b0;
    end
  end

  // Control flags of the auxiliary sequence
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aux_wait_q <= 1'b0;
      rd_lo_q    <= 1'b0;
      rd_hi_q    <= 1'b0;
      wb_en_q    <= 1'b0;
      merge_q    <= 1'b0;
      store_en_q <= 1'b0;
      area_q     <= 1'b0;
      cap_hi_q   <= 1'b0;
      cap_lo_q   <= 1'b0;
      gate_q     <= 1'b0;
    end else if (run) begin
      unique case (slot_q)
        buf_chan_pkg::T_START: begin
          aux_wait_q <= 1'b1;
          rd_lo_q    <= 1'b1;
          rd_hi_q    <= 1'b1;
        end
        buf_chan_pkg::T_CORE: begin
          area_q   <= in_area(ccr_q[2*ADDR_W-1:ADDR_W]);
          cap_hi_q <= 1'b0;
          cap_lo_q <= 1'b0;
        end
        buf_chan_pkg::T_AREA:  store_en_q <= area_q;
        buf_chan_pkg::T_INC: begin
          cap_hi_q <= core_addr[2];
          cap_lo_q <= core_addr[1];
          wb_en_q  <= 1'b1;
        end
        buf_chan_pkg::T_RDOFF: begin
          rd_lo_q <= 1'b0;
          rd_hi_q <= 1'b0;
        end
        buf_chan_pkg::T_RESUME: merge_q <= ~is_out & area_q;
        buf_chan_pkg::T_WBOFF:  wb_en_q <= 1'b0;
        buf_chan_pkg::T_OWN: begin
          merge_q    <= 1'b0;
          store_en_q <= 1'b0;
        end
        buf_chan_pkg::T_OGATE:  gate_q <= is_out;
        buf_chan_pkg::T_OGOFF:  gate_q <= 1'b0;
        buf_chan_pkg::T_DROP: begin
          rd_lo_q <= 1'b1;
          rd_hi_q <= 1'b1;
        end
        buf_chan_pkg::T_CLRAUX: begin
          if (!act_q) begin
            aux_wait_q <= 1'b0;
            rd_lo_q    <= 1'b0;
            rd_hi_q    <= 1'b0;
          end
        end
        default: ;
      endcase
    end else if (hss_q == buf_chan_pkg::HSS_PRESET) begin
      store_en_q <= 1'b1;
      rd_lo_q    <= act_q;
      rd_hi_q    <= act_q;
    end else if (hss_q == buf_chan_pkg::HSS_CHECK) begin
      store_en_q <= 1'b0;
      rd_lo_q    <= 1'b0;
      rd_hi_q    <= 1'b0;
    end
  end

  // Common compare word
  // upper current, lower terminal
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ccr_q <= '0;
    end else if (run) begin
      if (slot_q == buf_chan_pkg::T_CLRCCR || slot_q == buf_chan_pkg::T_RESUME
          || slot_q == buf_chan_pkg::T_CLRCMP) begin
        ccr_q <= '0;
      end else if (slot_q == buf_chan_pkg::T_LDCCR || slot_q == buf_chan_pkg::T_LDCMP) begin
        ccr_q <= rank7;
      end else if (slot_q == buf_chan_pkg::T_INC) begin
        ccr_q[2*ADDR_W-1:ADDR_W] <= ccr_q[2*ADDR_W-1:ADDR_W] + 15'h0001;
      end
    end else if (hss_q == buf_chan_pkg::HSS_STORE) begin
      ccr_q <= rank7;
    end
  end

  // Control word storage: writeback, input merge and program writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 1; i <= 6; i++) begin
        cw_u_q[i] <= '0;
        cw_l_q[i] <= '0;
      end
    end else if (run && slot_q == buf_chan_pkg::T_WBACK && wb_en_q) begin
      cw_u_q[sel_q] <= ccr_q[2*ADDR_W-1:ADDR_W];
    end else if (run && slot_q == buf_chan_pkg::T_XFER && merge_q) begin
      cw_u_q[sel_q] <= '1;
      cw_l_q[sel_q] <= '1;
    end else if (run && slot_q == buf_chan_pkg::T_MERGE && merge_q) begin
      cw_u_q[sel_q] <= cw_u_q[sel_q] & din_s2_q[UL +: ADDR_W];
      cw_l_q[sel_q] <= cw_l_q[sel_q] & din_s2_q[LL +: ADDR_W];
    end else if (hss_q == buf_chan_pkg::HSS_PRESET && !act_q) begin
      if (wr_u_q) begin
        cw_u_q[pend_q] <= '1;
      end else begin
        cw_l_q[pend_q] <= '1;
      end
    end else if (hss_q == buf_chan_pkg::HSS_STORE && !act_q) begin
      if (wr_u_q) begin
        cw_u_q[sel_q] <= cw_u_q[sel_q] & wdat_q;
      end else begin
        cw_l_q[sel_q] <= cw_l_q[sel_q] & wdat_q;
      end
    end
  end

  // Program control word reference and activate
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hss_q  <= buf_chan_pkg::HSS_IDLE;
      pend_q <= buf_chan_pkg::CODE_LO;
      act_q  <= 1'b0;
      wr_u_q <= 1'b0;
      wdat_q <= '0;
    end else begin
      unique case (hss_q)
        buf_chan_pkg::HSS_IDLE: begin
          if (reg_wr && !seq_q && code_ok(reg_addr[4:2])) begin
            if (reg_addr == buf_chan_pkg::OFS_ACT && code_ok(reg_wdata[2:0])) begin
              pend_q <= reg_wdata[2:0];
              act_q  <= 1'b1;
              hss_q  <= buf_chan_pkg::HSS_PRESET;
            end else if ((reg_addr & buf_chan_pkg::OFS_MASK) == buf_chan_pkg::OFS_CWU
                         || (reg_addr & buf_chan_pkg::OFS_MASK) == buf_chan_pkg::OFS_CWL) begin
              pend_q <= reg_addr[4:2];
              wr_u_q <= (reg_addr & buf_chan_pkg::OFS_MASK) == buf_chan_pkg::OFS_CWU;
              wdat_q <= reg_wdata[ADDR_W-1:0];
              hss_q  <= buf_chan_pkg::HSS_PRESET;
            end
          end else if (reg_wr && !seq_q && reg_addr == buf_chan_pkg::OFS_ACT
                       && code_ok(reg_wdata[2:0])) begin
            pend_q <= reg_wdata[2:0];
            act_q  <= 1'b1;
            hss_q  <= buf_chan_pkg::HSS_PRESET;
          end
        end
        buf_chan_pkg::HSS_PRESET: begin
          if (!aux_wait_q) begin
            hss_q <= buf_chan_pkg::HSS_STORE;
          end
        end
        buf_chan_pkg::HSS_STORE: hss_q <= buf_chan_pkg::HSS_CHECK;
        buf_chan_pkg::HSS_CHECK: begin
          act_q <= 1'b0;
          hss_q <= buf_chan_pkg::HSS_IDLE;
        end
      endcase
    end
  end

  // Buffer active flags
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      buffer_active <= '0;
    end else if ((run && slot_q == buf_chan_pkg::T_TERM)
                 || (hss_q == buf_chan_pkg::HSS_CHECK && act_q)) begin
      if (ccr_q[2*ADDR_W-1:ADDR_W] != ccr_q[ADDR_W-1:0]) begin
        buffer_active <= buffer_active | sel_hot;
      end else begin
        buffer_active <= buffer_active & ~sel_hot;
      end
    end
  end

  // Core storage access
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      core_start <= 1'b0;
      core_write <= 1'b0;
      core_addr  <= '0;
      core_wdata <= '0;
      rank_q     <= '0;
    end else begin
      core_start <= run && slot_q == buf_chan_pkg::T_CORE;
      core_write <= run && slot_q == buf_chan_pkg::T_XFER && !is_out;
      if (run && slot_q == buf_chan_pkg::T_CORE) begin
        core_addr <= ccr_q[2*ADDR_W-1:ADDR_W];
      end
      if (run && slot_q == buf_chan_pkg::T_XFER && !is_out) begin
        core_wdata <= din_s2_q;
      end
      if (run && slot_q == buf_chan_pkg::T_RESUME && core_done && is_out) begin
        rank_q <= area_q ? ((core_rdata & ~AMASK)
                  | (WORD_W'(cw_u_q[sel_q]) << UL) | (WORD_W'(cw_l_q[sel_q]) << LL))
                  : core_rdata;
      end
    end
  end

  // Equipment side outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      out_word    <= '0;
      out_load    <= '0;
      out_ready   <= '0;
      in_resume_b <= '1;
    end else begin
      out_load <= gate_q ? sel_hot : 6'h00;
      if (gate_q) begin
        out_word <= rank_q;
      end
      out_ready   <= (out_ready & ~req_s2_q)
                     | ((run && slot_q == buf_chan_pkg::T_SIGNAL && is_out) ? sel_hot : 6'h00);
      in_resume_b <= (in_resume_b | req_s2_q)
                     & ~((run && slot_q == buf_chan_pkg::T_SIGNAL && !is_out) ? sel_hot : 6'h00);
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == buf_chan_pkg::OFS_ACT) begin
        reg_rdata <= {26'h0, buffer_active};
      end else if (reg_addr == buf_chan_pkg::OFS_STAT) begin
        reg_rdata <= {16'h0, seq_q, store_en_q, even_busy_q, odd_busy_q,
                      act_q, sel_q, 2'h0, slot_q};
      end else if (code_ok(reg_addr[4:2]) && reg_addr[1:0] == 2'h0
                   && (reg_addr & buf_chan_pkg::OFS_MASK) == buf_chan_pkg::OFS_CWU) begin
        reg_rdata <= {17'h0, cw_u_q[reg_addr[4:2]]};
      end else if (code_ok(reg_addr[4:2]) && reg_addr[1:0] == 2'h0
                   && (reg_addr & buf_chan_pkg::OFS_MASK) == buf_chan_pkg::OFS_CWL) begin
        reg_rdata <= {17'h0, cw_l_q[reg_addr[4:2]]};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

/* logic/buf_chan_pkg.sv */
// Purpose: Shared constants for the buffer channel word update block.
// Assumes: One time slot per clk_sys cycle; channel codes 1..6.
// Notes:   Odd channel codes are input channels, even codes are output.
package buf_chan_pkg;

  // Widths of words and fields
  localparam int ADDR_W   = 15;
  localparam int WORD_W   = 48;
  localparam int SLOT_W   = 6;
  localparam int CODE_W   = 3;
  localparam int NCHAN    = 6;

  // Address portions of a storage word (2 x 15 bits = 30 address bits)
  localparam int UADDR_LSB = 24;
  localparam int LADDR_LSB = 0;

  // Time slots of the auxiliary sequence
  localparam logic [5:0] T_START  = 6'h00;
  localparam logic [5:0] T_CLRCCR = 6'h01;
  localparam logic [5:0] T_LDCCR  = 6'h02;
  localparam logic [5:0] T_CORE   = 6'h04;
  localparam logic [5:0] T_AREA   = 6'h05;
  localparam logic [5:0] T_INC    = 6'h06;
  localparam logic [5:0] T_RDOFF  = 6'h07;
  localparam logic [5:0] T_WBACK  = 6'h08;
  localparam logic [5:0] T_RESEL  = 6'h09;
  localparam logic [5:0] T_RESUME = 6'h0b;
  localparam logic [5:0] T_WBOFF  = 6'h0c;
  localparam logic [5:0] T_XFER   = 6'h0d;
  localparam logic [5:0] T_MERGE  = 6'h0e;
  localparam logic [5:0] T_OWN    = 6'h10;
  localparam logic [5:0] T_OGATE  = 6'h12;
  localparam logic [5:0] T_OGOFF  = 6'h14;
  localparam logic [5:0] T_SIGNAL = 6'h15;
  localparam logic [5:0] T_DROP   = 6'h16;
  localparam logic [5:0] T_CLRCMP = 6'h19;
  localparam logic [5:0] T_LDCMP  = 6'h1a;
  localparam logic [5:0] T_CLRAUX = 6'h20;
  localparam logic [5:0] T_TERM   = 6'h21;

  // Control word area bounds and channel code range
  localparam logic [14:0] AREA_LO = 15'h0001;
  localparam logic [14:0] AREA_HI = 15'h0006;
  localparam logic [2:0]  CODE_LO = 3'h1;
  localparam logic [2:0]  CODE_HI = 3'h6;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_ACT    = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_CWU    = 8'h20;
  localparam logic [7:0] OFS_CWL    = 8'h40;
  localparam logic [7:0] OFS_MASK   = 8'he0;

  // Program control word reference sequence
  typedef enum logic [1:0] {
    HSS_IDLE   = 2'b00,
    HSS_PRESET = 2'b01,
    HSS_STORE  = 2'b11,
    HSS_CHECK  = 2'b10
  } hss_state_e;

endpackage

/* dv/buf_chan_sva.sv */
// Purpose: Port checker for the buffer channel word update block.
// Assumes: One clock, rst_b low resets.
// Notes:   Bound to the buffer_channel_word_update module.
`timescale 1ns/1ps
module buf_chan_sva (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        core_start,
  input wire logic        core_write,
  input wire logic [5:0]  out_load,
  input wire logic [5:0]  out_ready,
  input wire logic [5:0]  in_resume_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  load_len_a: assert property ($rose(|out_load) |=> $stable(out_load) ##1 !(|out_load))
    else $error("output load not two cycles");
  load_one_a: assert property ($onehot0(out_load) && (out_load & 6'h15) == 6'h0)
    else $error("output load not one output channel");
  ready_after_a: assert property ($rose(|out_load) |-> ##2 (out_ready & ~$past(out_ready)) != 0)
    else $error("output ready late or missing");
  resume_after_a: assert property ($rose(core_write) |-> ##8 (~in_resume_b & $past(in_resume_b)) != 0)
    else $error("input resume late or missing");
  start_pulse_a: assert property (core_start |=> !core_start)
    else $error("core start longer than one cycle");
  write_apart_a: assert property (core_write |-> !core_start)
    else $error("core write beside core start");
  side_split_a: assert property ((out_ready & 6'h15) == 6'h0 && (in_resume_b & 6'h2a) == 6'h2a)
    else $error("ready or resume on wrong channel kind");
  cover property ($rose(|out_load));
  cover property ($rose(core_write));
  cover property ($fell(&in_resume_b));
endmodule
bind buffer_channel_word_update buf_chan_sva u_sva (.clk_sys, .rst_b, .reg_rd, .reg_rdata,
  .core_start, .core_write, .out_load, .out_ready, .in_resume_b);

/* dv/equip_model.sv */
// Purpose: Equipment adaptor model for the buffered channels.
// Assumes: One request at a time, commanded by the bench.
// Notes:   Data line shows the inverted word when no request stands.
`timescale 1ns/1ps
module equip_model (
  input  wire logic        clk_sys,
  input  wire logic [2:0]  go_ch,
  input  wire logic [47:0] go_word,
  input  wire logic [5:0]  out_ready,
  input  wire logic [5:0]  in_resume_b,
  output logic      [5:0]  chan_req_pin,
  output logic      [47:0] in_word_pin
);
  logic [5:0] ans, ans_q;  // Answer lines, last value
  assign ans = out_ready | ~in_resume_b;
  initial begin
    chan_req_pin = 6'h0;
    in_word_pin = 48'h0;
    ans_q = 6'h0;
  end
  // Raise request on command, drop on fresh answer
  always @(posedge clk_sys) begin
    ans_q <= ans;
    if ((chan_req_pin & ans & ~ans_q) != 6'h0) begin
      chan_req_pin <= 6'h0;
      in_word_pin <= ~in_word_pin;
    end else if (chan_req_pin == 6'h0 && go_ch != 3'h0) begin
      chan_req_pin <= 6'h1 << (go_ch - 3'h1);
      in_word_pin <= go_word;
    end
  end
endmodule

/* dv/buffer_channel_word_update_tb_top.sv */
// Purpose: Self-checking bench for the buffer channel word update block.
// Assumes: Core storage answers two cycles after each start.
// Notes:   Each channel is activated, then served twice to termination.
`timescale 1ns/1ps
module buffer_channel_word_update_tb_top;
  logic        clk_sys, rst_b, reg_wr, reg_rd, core_done, cd, core_start, core_write;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [14:0] core_addr, ca;
  logic [47:0] core_wdata, core_rdata, in_word_pin, out_word, go_word, ow, cw;
  logic [5:0]  chan_req_pin, out_load, out_ready, in_resume_b, buffer_active, mask;
  logic [2:0]  go_ch;
  int          bad_count, cmp_count, cyc, cur[7], term[7];
  buffer_channel_word_update u_dut (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .core_start, .core_write, .core_addr, .core_wdata, .core_rdata,
    .core_done, .chan_req_pin, .in_word_pin, .out_word, .out_load, .out_ready,
    .in_resume_b, .buffer_active);
  equip_model u_equip (.clk_sys, .go_ch, .go_word, .out_ready, .in_resume_b,
    .chan_req_pin, .in_word_pin);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Core storage model, captures, hang limit
  always @(posedge clk_sys) begin
    cd <= core_start;
    if (core_start) begin
      core_done <= 1'b0;
      core_rdata <= {16'($urandom), $urandom};
      ca <= core_addr;
    end else if (cd) core_done <= 1'b1;
    if (core_write) cw <= core_wdata;
    if (out_load != 6'h0) ow <= out_word;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys); reg_wr <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys); reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic poll(input int b);
    int n;
    n = 0; rv = 32'hffff;
    while (rv[b] && n < 300) begin rd(8'h04, rv); n++; end
  endtask
  task automatic act(input int c, input int gap);
    cur[c] = 32'h100 + ($urandom % 32'h3000);
    term[c] = cur[c] + gap;
    mask[c-1] = (gap != 0);
    wr(8'h20 + 8'(4*c), 32'(cur[c])); wr(8'h40 + 8'(4*c), 32'(term[c]));
    rd(8'h40 + 8'(4*c), rv); chk(48'(rv), 48'(term[c]));
    wr(8'h00, 32'(c)); poll(11);
    rd(8'h00, rv); chk(48'(rv), 48'(mask));
  endtask
  task automatic xfer(input int c);
    logic [47:0] w;
    int n;
    w = {16'($urandom), $urandom};
    go_word <= w; go_ch <= 3'(c);
    repeat (2) @(posedge clk_sys);
    go_ch <= 3'h0; n = 0;
    while (chan_req_pin != 6'h0 && n < 300) begin @(posedge clk_sys); n++; end
    poll(15);
    chk(48'(ca), 48'(cur[c]));
    if (c % 2) chk(cw, w); else chk(ow, core_rdata);
    cur[c]++;
    mask[c-1] = (cur[c] != term[c]);
    rd(8'h20 + 8'(4*c), rv); chk(48'(rv), 48'(cur[c]));
    chk(48'(buffer_active), 48'(mask));
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0;
    core_done = 1'b0; cd = 1'b0; core_rdata = 48'h0; go_ch = 3'h0; go_word = 48'h0;
    bad_count = 0; cmp_count = 0; cyc = 0; mask = 6'h0;
    void'($urandom(32'h9b4d));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys); #1;
    chk(48'({in_resume_b, out_ready, out_load, buffer_active}), 48'hfc0000);
    $display("Test reset done");
    for (int c = 1; c <= 6; c++) begin
      act(c, 2);
      xfer(c); xfer(c);
      $display("Test channel %0d done", c);
    end
    act(3, 0);
    rd(8'h80, rv); chk(48'(rv), 48'h0);
    $display("Test terminate and unmapped done");
    wrap_up();
  end
endmodule
